// ==== hw/phy_mgmt_pkg.sv ====
// constants and types shared by the phy management agent
package phy_mgmt_pkg;
  // parameter identifiers on the request port
  localparam logic [3:0] PAR_DUPLEX      = 4'h0;
  localparam logic [3:0] PAR_LOOPBACK    = 4'h1;
  localparam logic [3:0] PAR_PREAMBLE    = 4'h2;
  localparam logic [3:0] PAR_GAP         = 4'h3;
  localparam logic [3:0] PAR_SKEW        = 4'h4;
  localparam logic [3:0] PAR_TX_ENABLE   = 4'h5;
  localparam logic [3:0] PAR_RX_ENABLE   = 4'h6;
  localparam logic [3:0] PAR_PREF_RX     = 4'h7;
  localparam logic [3:0] PAR_TX_OUTPUT   = 4'h8;
  localparam logic [3:0] PAR_RX_SOURCE   = 4'h9;
  localparam logic [3:0] PAR_LOOP        = 4'hA;
  // variant selector on a write
  localparam logic [1:0] VAR_A           = 2'h0;
  localparam logic [1:0] VAR_B           = 2'h1;
  // per-variable status codes
  localparam logic [1:0] ST_OK           = 2'h0;
  localparam logic [1:0] ST_FAIL         = 2'h1;
  localparam logic [1:0] ST_INVALID      = 2'h2;
  // permitted-value limits
  localparam logic [1:0] LOOPBACK_MAX    = 2'h2;
  localparam logic [3:0] PREF_RX_MAX     = 4'h8;
  localparam logic [1:0] RX_SOURCE_MAX   = 2'h2;
  localparam int         NUM_CHANNELS    = 8;
  localparam int         MAX_PAIRS       = 3;
  // reset values: first of each permitted list
  localparam logic       DUPLEX_RST      = 1'b0;
  localparam logic [1:0] LOOPBACK_RST    = 2'h0;
  localparam logic [2:0] COUNT_RST       = 3'h0;
  localparam logic [7:0] CHAN_EN_RST     = 8'hFF;
  localparam logic [3:0] PREF_RX_RST     = 4'h0;
  localparam logic       TX_OUTPUT_RST   = 1'b1;
  localparam logic [1:0] RX_SOURCE_RST   = 2'h0;
  localparam logic       LOOP_RST        = 1'b0;
  // event names
  localparam logic       EVT_TERMINAL    = 1'b0;
  localparam logic       EVT_LINE        = 1'b1;
  // transmit framing: basic preamble and basic gap length in sequences
  localparam logic [3:0] BASIC_PRE_SEQ   = 4'h1;
  localparam logic [3:0] BASIC_GAP_SEQ   = 4'h1;
  typedef enum logic [1:0] {FR_IDLE, FR_EXT_PRE, FR_BASIC_PRE, FR_GAP} frame_state_t;
endpackage

// ==== hw/tx_frame_sequencer.sv ====
// sequences preamble extensions, basic preamble and silent gap per frame
`timescale 1ns/100ps
module tx_frame_sequencer (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       tx_start_in,
  input  wire logic       tx_done_in,
  input  wire logic [2:0] pre_ext_in,
  input  wire logic [2:0] gap_ext_in,
  output logic            ext_pre_out,
  output logic            basic_pre_out,
  output logic            tx_silent_out,
  output logic            data_go_out
);
  phy_mgmt_pkg::frame_state_t state_reg;
  logic [3:0]                 cnt_reg;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state_reg <= phy_mgmt_pkg::FR_IDLE;
      cnt_reg   <= 4'h0;
    end else begin
      case (state_reg)
        phy_mgmt_pkg::FR_IDLE: begin
          if (tx_start_in && pre_ext_in != 3'h0) begin
            state_reg <= phy_mgmt_pkg::FR_EXT_PRE;
            cnt_reg   <= {1'b0, pre_ext_in};
          end else if (tx_start_in) begin
            state_reg <= phy_mgmt_pkg::FR_BASIC_PRE;
            cnt_reg   <= phy_mgmt_pkg::BASIC_PRE_SEQ;
          end else if (tx_done_in) begin
            state_reg <= phy_mgmt_pkg::FR_GAP;
            cnt_reg   <= phy_mgmt_pkg::BASIC_GAP_SEQ + {1'b0, gap_ext_in};
          end
        end
        phy_mgmt_pkg::FR_EXT_PRE: begin
          if (cnt_reg == 4'h1) begin
            state_reg <= phy_mgmt_pkg::FR_BASIC_PRE;
            cnt_reg   <= phy_mgmt_pkg::BASIC_PRE_SEQ;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        phy_mgmt_pkg::FR_BASIC_PRE: begin
          if (cnt_reg == 4'h1) begin
            state_reg <= phy_mgmt_pkg::FR_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        phy_mgmt_pkg::FR_GAP: begin
          if (cnt_reg == 4'h1) begin
            state_reg <= phy_mgmt_pkg::FR_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: state_reg <= phy_mgmt_pkg::FR_IDLE;
      endcase
    end
  end

  assign ext_pre_out   = (state_reg == phy_mgmt_pkg::FR_EXT_PRE);
  assign basic_pre_out = (state_reg == phy_mgmt_pkg::FR_BASIC_PRE);
  assign tx_silent_out = (state_reg == phy_mgmt_pkg::FR_GAP);
  assign data_go_out   = (state_reg == phy_mgmt_pkg::FR_BASIC_PRE) && (cnt_reg == 4'h1);

  a_gap_silent_len: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (state_reg == phy_mgmt_pkg::FR_IDLE && tx_done_in && !tx_start_in && gap_ext_in == 3'h0)
      |=> tx_silent_out ##1 !tx_silent_out)
    else $error("gap length wrong");
  a_ext_before_basic: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    basic_pre_out |=> !ext_pre_out)
    else $error("extension after basic preamble");
endmodule // tx_frame_sequencer

// ==== hw/phy_management_param_agent.sv ====
// phy management agent: parameters, write/read/reset confirms, events
`timescale 1ns/100ps
// How it works
// - reset loads first permitted value everywhere
// - loop-back selector with three settings
// - preamble extension count zero to seven
// - gap extension count zero to seven
// - inter-channel skew setting zero to seven
// - eight channel transmit and receive enables
// - preferred receive channel none or 1-8
// - extension sequences precede basic preamble
// - transmitter silent through whole gap
// - one write confirmation with status
// - read returns failure or current value
// - unrequested change raises named event notice
// - management reset equals power-on defaults
// - reset confirmation is a one-cycle pulse with no status
// - reset/event always; write/read build options
// - alternate variant reuses same behaviour
// - alternate write carries 1-3 pairs, statuses
// - receive source cable a, b, random
// - basic reset resets all phy functions
module phy_management_param_agent #(
  parameter bit HAS_WRITE = 1'b1,
  parameter bit HAS_READ  = 1'b1
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  // requests
  input  wire logic       reinit_req_in,
  input  wire logic       write_req_in,
  input  wire logic [1:0] write_variant_in,
  input  wire logic [1:0] write_count_in,
  input  wire logic [3:0] write_name0_in,
  input  wire logic [3:0] write_value0_in,
  input  wire logic [3:0] write_name1_in,
  input  wire logic [3:0] write_value1_in,
  input  wire logic [3:0] write_name2_in,
  input  wire logic [3:0] write_value2_in,
  input  wire logic       read_req_in,
  input  wire logic [3:0] read_name_in,
  output logic            req_ready_out,
  // confirmations
  output logic            reinit_cnf_out,
  output logic            write_cnf_out,
  output logic [1:0]      write_status0_out,
  output logic [1:0]      write_status1_out,
  output logic [1:0]      write_status2_out,
  output logic            read_cnf_out,
  output logic            read_fail_out,
  output logic [7:0]      read_value_out,
  // unrequested changes from the phy entity
  input  wire logic       terminal_side_fault_in,
  input  wire logic       line_side_fault_in,
  output logic            event_out,
  output logic            event_name_out,
  // operating parameters
  output logic            half_duplex_out,
  output logic [1:0]      loopback_out,
  output logic [2:0]      preamble_ext_out,
  output logic [2:0]      gap_ext_out,
  output logic [2:0]      skew_out,
  output logic [7:0]      tx_chan_en_out,
  output logic [7:0]      rx_chan_en_out,
  output logic [3:0]      pref_rx_out,
  output logic            tx_output_en_out,
  output logic [1:0]      rx_source_out,
  output logic            loop_en_out,
  output logic            phy_reset_out,
  // transmit framing
  input  wire logic       tx_start_in,
  input  wire logic       tx_done_in,
  output logic            ext_pre_out,
  output logic            basic_pre_out,
  output logic            tx_silent_out,
  output logic            data_go_out
);
  logic       half_duplex_reg;
  logic [1:0] loopback_reg;
  logic [2:0] preamble_reg;
  logic [2:0] gap_reg;
  logic [2:0] skew_reg;
  logic [7:0] tx_en_reg;
  logic [7:0] rx_en_reg;
  logic [3:0] pref_rx_reg;
  logic       tx_out_reg;
  logic [1:0] rx_src_reg;
  logic       loop_reg;
  logic       busy_reg;
  logic       fault_t_reg;
  logic       fault_l_reg;
  logic       pend_t_reg;
  logic       pend_l_reg;
  logic [3:0] names  [phy_mgmt_pkg::MAX_PAIRS];
  logic [3:0] values [phy_mgmt_pkg::MAX_PAIRS];
  logic [1:0] status_next [phy_mgmt_pkg::MAX_PAIRS];
  logic       set_en [phy_mgmt_pkg::MAX_PAIRS];
  logic       do_write;
  logic       do_read;
  logic       do_reinit;
  logic       rst_all;

  // value check shared by write path and its status
  function automatic logic value_ok(input logic [3:0] name, input logic [3:0] val, input logic [1:0] variant);
    logic ok;
    ok = 1'b0;
    if (variant == phy_mgmt_pkg::VAR_A) begin
      case (name)
        phy_mgmt_pkg::PAR_DUPLEX:    ok = (val[3:1] == 3'h0);
        phy_mgmt_pkg::PAR_LOOPBACK:  ok = (val <= {2'h0, phy_mgmt_pkg::LOOPBACK_MAX});
        phy_mgmt_pkg::PAR_PREAMBLE:  ok = !val[3];
        phy_mgmt_pkg::PAR_GAP:       ok = !val[3];
        phy_mgmt_pkg::PAR_SKEW:      ok = !val[3];
        phy_mgmt_pkg::PAR_TX_ENABLE: ok = 1'b1;
        phy_mgmt_pkg::PAR_RX_ENABLE: ok = 1'b1;
        phy_mgmt_pkg::PAR_PREF_RX:   ok = (val <= phy_mgmt_pkg::PREF_RX_MAX);
        default:                     ok = 1'b0;
      endcase
    end else begin
      case (name)
        phy_mgmt_pkg::PAR_TX_OUTPUT: ok = (val[3:1] == 3'h0);
        phy_mgmt_pkg::PAR_RX_SOURCE: ok = (val <= {2'h0, phy_mgmt_pkg::RX_SOURCE_MAX});
        phy_mgmt_pkg::PAR_LOOP:      ok = (val[3:1] == 3'h0);
        default:                     ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  assign names[0]  = write_name0_in;
  assign names[1]  = write_name1_in;
  assign names[2]  = write_name2_in;
  assign values[0] = write_value0_in;
  assign values[1] = write_value1_in;
  assign values[2] = write_value2_in;

  // one request at a time; reset wins, then write, then read
  assign req_ready_out = !busy_reg;
  assign do_reinit     = !busy_reg && reinit_req_in;
  assign do_write      = !busy_reg && !reinit_req_in && write_req_in && HAS_WRITE;
  assign do_read       = !busy_reg && !reinit_req_in && !write_req_in && read_req_in && HAS_READ;
  assign rst_all       = !rstn_in || do_reinit;

  // per-slot status; channel enable writes carry channel in value[2:0] and level in value[3]
  generate
    for (genvar i = 0; i < phy_mgmt_pkg::MAX_PAIRS; i++) begin : g_slot
      always_comb begin
        status_next[i] = phy_mgmt_pkg::ST_OK;
        set_en[i]      = 1'b0;
        if (write_variant_in == phy_mgmt_pkg::VAR_A && i != 0) begin
          status_next[i] = phy_mgmt_pkg::ST_OK;
        end else if (write_variant_in == phy_mgmt_pkg::VAR_B &&
                     (write_count_in == 2'h0 || i >= write_count_in)) begin
          status_next[i] = (write_count_in == 2'h0) ? phy_mgmt_pkg::ST_INVALID : phy_mgmt_pkg::ST_OK;
        end else if (write_variant_in > phy_mgmt_pkg::VAR_B) begin
          status_next[i] = phy_mgmt_pkg::ST_INVALID;
        end else if (!value_ok(names[i], values[i], write_variant_in)) begin
          status_next[i] = phy_mgmt_pkg::ST_FAIL;
        end else begin
          set_en[i] = do_write;
        end
      end
    end
  endgenerate

  // parameter store
  always_ff @(posedge ref_clk_in) begin
    if (rst_all) begin
      half_duplex_reg <= phy_mgmt_pkg::DUPLEX_RST;
      loopback_reg    <= phy_mgmt_pkg::LOOPBACK_RST;
      preamble_reg    <= phy_mgmt_pkg::COUNT_RST;
      gap_reg         <= phy_mgmt_pkg::COUNT_RST;
      skew_reg        <= phy_mgmt_pkg::COUNT_RST;
      tx_en_reg       <= phy_mgmt_pkg::CHAN_EN_RST;
      rx_en_reg       <= phy_mgmt_pkg::CHAN_EN_RST;
      pref_rx_reg     <= phy_mgmt_pkg::PREF_RX_RST;
      tx_out_reg      <= phy_mgmt_pkg::TX_OUTPUT_RST;
      rx_src_reg      <= phy_mgmt_pkg::RX_SOURCE_RST;
      loop_reg        <= phy_mgmt_pkg::LOOP_RST;
    end else begin
      for (int i = 0; i < phy_mgmt_pkg::MAX_PAIRS; i++) begin
        if (set_en[i]) begin
          case (names[i])
            phy_mgmt_pkg::PAR_DUPLEX:    half_duplex_reg <= values[i][0];
            phy_mgmt_pkg::PAR_LOOPBACK:  loopback_reg    <= values[i][1:0];
            phy_mgmt_pkg::PAR_PREAMBLE:  preamble_reg    <= values[i][2:0];
            phy_mgmt_pkg::PAR_GAP:       gap_reg         <= values[i][2:0];
            phy_mgmt_pkg::PAR_SKEW:      skew_reg        <= values[i][2:0];
            // value[3] = disabled, value[2:0] = channel minus one
            phy_mgmt_pkg::PAR_TX_ENABLE: tx_en_reg[values[i][2:0]] <= !values[i][3];
            phy_mgmt_pkg::PAR_RX_ENABLE: rx_en_reg[values[i][2:0]] <= !values[i][3];
            phy_mgmt_pkg::PAR_PREF_RX:   pref_rx_reg     <= values[i];
            phy_mgmt_pkg::PAR_TX_OUTPUT: tx_out_reg      <= !values[i][0];
            phy_mgmt_pkg::PAR_RX_SOURCE: rx_src_reg      <= values[i][1:0];
            phy_mgmt_pkg::PAR_LOOP:      loop_reg        <= values[i][0];
            default:                     loop_reg        <= loop_reg;
          endcase
        end
      end
    end
  end

  // confirmations, one cycle after acceptance
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      busy_reg          <= 1'b0;
      reinit_cnf_out    <= 1'b0;
      write_cnf_out     <= 1'b0;
      read_cnf_out      <= 1'b0;
      read_fail_out     <= 1'b0;
      read_value_out    <= 8'h00;
      write_status0_out <= phy_mgmt_pkg::ST_OK;
      write_status1_out <= phy_mgmt_pkg::ST_OK;
      write_status2_out <= phy_mgmt_pkg::ST_OK;
    end else begin
      busy_reg       <= do_reinit || do_write || do_read;
      reinit_cnf_out <= do_reinit;
      write_cnf_out  <= do_write;
      read_cnf_out   <= do_read;
      if (do_write) begin
        write_status0_out <= status_next[0];
        write_status1_out <= status_next[1];
        write_status2_out <= status_next[2];
      end
      if (do_read) begin
        read_fail_out  <= 1'b0;
        read_value_out <= 8'h00;
        case (read_name_in)
          phy_mgmt_pkg::PAR_DUPLEX:    read_value_out <= {7'h00, half_duplex_reg};
          phy_mgmt_pkg::PAR_LOOPBACK:  read_value_out <= {6'h00, loopback_reg};
          phy_mgmt_pkg::PAR_PREAMBLE:  read_value_out <= {5'h00, preamble_reg};
          phy_mgmt_pkg::PAR_GAP:       read_value_out <= {5'h00, gap_reg};
          phy_mgmt_pkg::PAR_SKEW:      read_value_out <= {5'h00, skew_reg};
          phy_mgmt_pkg::PAR_TX_ENABLE: read_value_out <= tx_en_reg;
          phy_mgmt_pkg::PAR_RX_ENABLE: read_value_out <= rx_en_reg;
          phy_mgmt_pkg::PAR_PREF_RX:   read_value_out <= {4'h0, pref_rx_reg};
          phy_mgmt_pkg::PAR_TX_OUTPUT: read_value_out <= {7'h00, !tx_out_reg};
          phy_mgmt_pkg::PAR_RX_SOURCE: read_value_out <= {6'h00, rx_src_reg};
          phy_mgmt_pkg::PAR_LOOP:      read_value_out <= {7'h00, loop_reg};
          default:                     read_fail_out  <= 1'b1;
        endcase
      end
    end
  end

  // fault edges; terminal wins a collision and the line notice is held pending until no terminal notice is due
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      fault_t_reg    <= 1'b0;
      fault_l_reg    <= 1'b0;
      pend_t_reg     <= 1'b0;
      pend_l_reg     <= 1'b0;
      event_out      <= 1'b0;
      event_name_out <= phy_mgmt_pkg::EVT_TERMINAL;
    end else begin
      fault_t_reg <= terminal_side_fault_in;
      fault_l_reg <= line_side_fault_in;
      event_out   <= 1'b0;
      if (pend_t_reg || (terminal_side_fault_in && !fault_t_reg)) begin
        event_out      <= 1'b1;
        event_name_out <= phy_mgmt_pkg::EVT_TERMINAL;
        pend_t_reg     <= 1'b0;
        pend_l_reg     <= pend_l_reg || (line_side_fault_in && !fault_l_reg);
      end else if (pend_l_reg || (line_side_fault_in && !fault_l_reg)) begin
        event_out      <= 1'b1;
        event_name_out <= phy_mgmt_pkg::EVT_LINE;
        pend_l_reg     <= 1'b0;
      end
    end
  end

  assign half_duplex_out  = half_duplex_reg;
  assign loopback_out     = loopback_reg;
  assign preamble_ext_out = preamble_reg;
  assign gap_ext_out      = gap_reg;
  assign skew_out         = skew_reg;
  assign tx_chan_en_out   = tx_en_reg;
  assign rx_chan_en_out   = rx_en_reg;
  assign pref_rx_out      = pref_rx_reg;
  assign tx_output_en_out = tx_out_reg;
  assign rx_source_out    = rx_src_reg;
  assign loop_en_out      = loop_reg;
  assign phy_reset_out    = rst_all;

  tx_frame_sequencer u_seq (
    .ref_clk_in    (ref_clk_in),
    .rstn_in       (!rst_all),
    .tx_start_in   (tx_start_in),
    .tx_done_in    (tx_done_in),
    .pre_ext_in    (preamble_reg),
    .gap_ext_in    (gap_reg),
    .ext_pre_out   (ext_pre_out),
    .basic_pre_out (basic_pre_out),
    .tx_silent_out (tx_silent_out),
    .data_go_out   (data_go_out)
  );

  a_reinit_defaults: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    do_reinit |=> tx_out_reg && rx_src_reg == 2'h0 && !loop_reg && tx_en_reg == 8'hFF)
    else $error("reinit defaults wrong");
  a_reinit_confirm: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    reinit_req_in && req_ready_out |=> reinit_cnf_out ##1 !reinit_cnf_out)
    else $error("reinit confirm missing");
  a_write_confirm: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    do_write |=> write_cnf_out && !read_cnf_out)
    else $error("write confirm missing");
  a_one_outstanding: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (write_cnf_out || read_cnf_out || reinit_cnf_out) |-> !req_ready_out)
    else $error("accepted while confirming");
  a_bad_read_fails: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    do_read && read_name_in > phy_mgmt_pkg::PAR_LOOP |=> read_fail_out)
    else $error("bad read not failed");
  a_pref_in_range: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    pref_rx_reg <= phy_mgmt_pkg::PREF_RX_MAX)
    else $error("preferred channel out of range");
  a_event_on_fault: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $rose(terminal_side_fault_in) |=> event_out && event_name_out == phy_mgmt_pkg::EVT_TERMINAL)
    else $error("fault event missing");
  a_loopback_range: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    loopback_reg <= phy_mgmt_pkg::LOOPBACK_MAX)
    else $error("loopback out of range");
  a_invalid_count: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    do_write && write_variant_in == phy_mgmt_pkg::VAR_B && write_count_in == 2'h0
      |=> write_status0_out == phy_mgmt_pkg::ST_INVALID)
    else $error("empty write not invalid");
  a_read_confirm: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    do_read |=> read_cnf_out && !write_cnf_out)
    else $error("read confirm missing");
  a_reset_counts: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    do_reinit |=> preamble_reg == phy_mgmt_pkg::COUNT_RST && gap_reg == phy_mgmt_pkg::COUNT_RST && !half_duplex_reg)
    else $error("counts not reset");
  a_reinit_channels: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    do_reinit |=> tx_en_reg == phy_mgmt_pkg::CHAN_EN_RST && rx_en_reg == phy_mgmt_pkg::CHAN_EN_RST)
    else $error("channels not re-enabled");
  a_pref_reset: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    do_reinit |=> pref_rx_reg == phy_mgmt_pkg::PREF_RX_RST && loopback_reg == phy_mgmt_pkg::LOOPBACK_RST)
    else $error("preferred channel not reset");
  a_ready_returns: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (write_cnf_out || read_cnf_out || reinit_cnf_out) |=> req_ready_out)
    else $error("ready not restored");
endmodule // phy_management_param_agent

// ==== sim/mgmt_client_model.sv ====
// management client model: one request at a time towards the agent
`timescale 1ns/100ps
module mgmt_client_model (
  input  wire logic        ref_clk_in,
  input  wire logic        req_ready_in,
  output logic             reinit_req_out,
  output logic             write_req_out,
  output logic [1:0]       variant_out,
  output logic [1:0]       count_out,
  output logic [11:0]      names_out,
  output logic [11:0]      values_out,
  output logic             read_req_out,
  output logic [3:0]       read_name_out
);
  initial begin
    {reinit_req_out, write_req_out, read_req_out, variant_out, count_out, read_name_out} = '0;
    names_out = 12'h000;
    values_out = 12'h000;
  end

  // kind 0 reinit, 1 write, 2 read; returns at the falling edge after the taken edge
  task automatic send(input int kind, input logic [1:0] vr, cn, input logic [11:0] nm, vl);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    while (req_ready_in !== 1'b1 && n < 8) begin
      @(negedge ref_clk_in);
      n++;
    end
    variant_out = vr;
    count_out = cn;
    names_out = nm;
    values_out = vl;
    read_name_out = nm[3:0];
    reinit_req_out = (kind == 0);
    write_req_out = (kind == 1);
    read_req_out = (kind == 2);
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    {reinit_req_out, write_req_out, read_req_out} = 3'h0;
    // released fields are scrambled so stale values cannot pass for new ones
    names_out = ~nm;
    values_out = ~vl;
    read_name_out = ~nm[3:0];
  endtask
endmodule // mgmt_client_model

// ==== sim/testbench.sv ====
// self-checking bench for the phy management agent
`timescale 1ns/100ps
module testbench;
  logic        ref_clk_in, rstn_in, reinit_req_in, write_req_in, read_req_in, req_ready_out;
  logic        reinit_cnf_out, write_cnf_out, read_cnf_out, read_fail_out, event_out, event_name_out;
  logic        terminal_side_fault_in, line_side_fault_in, half_duplex_out, tx_output_en_out, loop_en_out;
  logic        phy_reset_out, tx_start_in, tx_done_in, ext_pre_out, basic_pre_out, tx_silent_out, data_go_out;
  logic [1:0]  write_variant_in, write_count_in, write_status0_out, write_status1_out, write_status2_out;
  logic [1:0]  loopback_out, rx_source_out, e_lb, e_src;
  logic [2:0]  preamble_ext_out, gap_ext_out, skew_out, e_pre, e_gap, e_skew;
  logic [3:0]  read_name_in, pref_rx_out, e_pref;
  logic [7:0]  read_value_out, tx_chan_en_out, rx_chan_en_out, e_tx, e_rx;
  logic [11:0] nm, vl;
  logic [31:0] s;
  logic        e_dup, e_txo, e_loop;
  int          err_total, tests_run;
  logic [7:0]  corner [6] = '{8'h78, 8'h79, 8'h12, 8'h13, 8'h27, 8'h28};
  wire  [35:0] params = {half_duplex_out, loopback_out, preamble_ext_out, gap_ext_out, skew_out, tx_chan_en_out,
                         rx_chan_en_out, pref_rx_out, tx_output_en_out, rx_source_out, loop_en_out};
  wire  [35:0] expv = {e_dup, e_lb, e_pre, e_gap, e_skew, e_tx, e_rx, e_pref, e_txo, e_src, e_loop};

  phy_management_param_agent u_phy_management_param_agent (.*, .write_name0_in(nm[3:0]), .write_value0_in(vl[3:0]),
    .write_name1_in(nm[7:4]), .write_value1_in(vl[7:4]), .write_name2_in(nm[11:8]), .write_value2_in(vl[11:8]));
  mgmt_client_model u_mgmt_client_model (.ref_clk_in, .req_ready_in(req_ready_out), .reinit_req_out(reinit_req_in),
    .write_req_out(write_req_in), .variant_out(write_variant_in), .count_out(write_count_in), .names_out(nm),
    .values_out(vl), .read_req_out(read_req_in), .read_name_out(read_name_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic ok(input logic [3:0] n, v);
    case (n)
      4'h0: ok = (v < 4'h2);
      4'h1: ok = (v < 4'h3);
      4'h2, 4'h3, 4'h4: ok = (v < 4'h8);
      4'h5, 4'h6: ok = 1'b1;
      4'h7: ok = (v < 4'h9);
      default: ok = 1'b0;
    endcase
  endfunction

  task automatic set_defaults();
    {e_dup, e_lb, e_pre, e_gap, e_skew} = '0;
    {e_tx, e_rx} = 16'hFFFF;
    e_pref = 4'h0;
    {e_txo, e_src, e_loop} = 4'h8;
  endtask

  task automatic chk(input string what, input logic [35:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] vr, cn, input logic [11:0] n, v, input logic [5:0] st);
    u_mgmt_client_model.send(1, vr, cn, n, v);
    chk("write_cnf", write_cnf_out, 1'b1);
    chk("status", {write_status2_out, write_status1_out, write_status0_out}, st);
    chk("params", params, expv);
    chk("ready", req_ready_out, 1'b0);
    chk("phy_reset", phy_reset_out, 1'b0);
  endtask

  // first variant write; expectation follows the permitted ranges
  task automatic put(input logic [3:0] n, v);
    logic g;
    g = ok(n, v);
    if (g && n == 4'h0) e_dup = v[0];
    if (g && n == 4'h1) e_lb = v[1:0];
    if (g && n == 4'h2) e_pre = v[2:0];
    if (g && n == 4'h3) e_gap = v[2:0];
    if (g && n == 4'h4) e_skew = v[2:0];
    if (g && n == 4'h5) e_tx[v[2:0]] = ~v[3];
    if (g && n == 4'h6) e_rx[v[2:0]] = ~v[3];
    if (g && n == 4'h7) e_pref = v;
    wr(phy_mgmt_pkg::VAR_A, 2'h1, {8'h00, n}, {8'h00, v}, {4'h0, g ? phy_mgmt_pkg::ST_OK : phy_mgmt_pkg::ST_FAIL});
  endtask

  task automatic rd(input logic [3:0] n);
    logic [7:0] v;
    v = n == 4'h0 ? e_dup : n == 4'h1 ? e_lb : n == 4'h2 ? e_pre : n == 4'h3 ? e_gap : n == 4'h4 ? e_skew :
        n == 4'h5 ? e_tx : n == 4'h6 ? e_rx : n == 4'h7 ? e_pref : n == 4'h8 ? !e_txo : n == 4'h9 ? e_src : e_loop;
    u_mgmt_client_model.send(2, 2'h0, 2'h0, {8'h00, n}, 12'h000);
    chk("read_cnf", read_cnf_out, 1'b1);
    chk("read_fail", read_fail_out, n == 4'hF);
    if (n != 4'hF) chk("read_value", read_value_out, v);
  endtask

  // st 1 starts a frame, 0 ends one; k is the extension count in force
  task automatic frame(input logic st, input logic [2:0] k);
    @(negedge ref_clk_in);
    tx_start_in = st;
    tx_done_in = ~st;
    @(negedge ref_clk_in);
    {tx_start_in, tx_done_in} = 2'h0;
    for (int i = 0; i < 10; i++) begin
      if (st) chk("preamble", {ext_pre_out, basic_pre_out, data_go_out}, {i < k, i == k, i == k});
      else chk("gap", tx_silent_out, i <= k);
      @(negedge ref_clk_in);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    {rstn_in, terminal_side_fault_in, line_side_fault_in, tx_start_in, tx_done_in} = 5'h00;
    err_total = 0;
    tests_run = 0;
    set_defaults();
    repeat (4) @(negedge ref_clk_in);
    chk("phy_reset", phy_reset_out, 1'b1);
    chk("params", params, expv);
    rstn_in = 1'b1;
    for (int k = 0; k < 8; k += 7) begin
      put(4'h2, k[3:0]);
      put(4'h3, k[3:0]);
      frame(1'b1, e_pre);
      frame(1'b0, e_gap);
    end
    foreach (corner[j]) put(corner[j][7:4], corner[j][3:0]);
    s = 32'h7E19;
    for (int i = 0; i < 48; i++) begin
      s = lfsr(s);
      put((s[6:3] == 4'h0) ? 4'hF : {1'b0, s[2:0]}, s[11:8]);
      rd((s[6:3] == 4'h0) ? 4'hF : {1'b0, s[2:0]});
    end
    // alternate variant: a bad middle slot fails alone
    {e_txo, e_loop} = 2'h1;
    wr(phy_mgmt_pkg::VAR_B, 2'h3, 12'hA98, 12'h131, {phy_mgmt_pkg::ST_OK, phy_mgmt_pkg::ST_FAIL, 2'h0});
    wr(phy_mgmt_pkg::VAR_B, 2'h0, 12'hA98, 12'h000, {3{phy_mgmt_pkg::ST_INVALID}});
    e_src = 2'h1;
    wr(phy_mgmt_pkg::VAR_B, 2'h2, 12'h899, 12'h012, 6'h00);
    wr(2'h2, 2'h1, 12'hA98, 12'h131, {3{phy_mgmt_pkg::ST_INVALID}});
    for (int n = 8; n < 11; n++) rd(n[3:0]);
    set_defaults();
    u_mgmt_client_model.send(0, 2'h0, 2'h0, 12'h000, 12'h000);
    chk("reinit_cnf", reinit_cnf_out, 1'b1);
    chk("params", params, expv);
    terminal_side_fault_in = 1'b1;
    @(negedge ref_clk_in);
    chk("event", {event_out, event_name_out}, {1'b1, phy_mgmt_pkg::EVT_TERMINAL});
    @(negedge ref_clk_in);
    chk("event", event_out, 1'b0);
    terminal_side_fault_in = 1'b0;
    @(negedge ref_clk_in);
    {terminal_side_fault_in, line_side_fault_in} = 2'h3;
    @(negedge ref_clk_in);
    chk("event", {event_out, event_name_out}, {1'b1, phy_mgmt_pkg::EVT_TERMINAL});
    @(negedge ref_clk_in);
    chk("event", {event_out, event_name_out}, {1'b1, phy_mgmt_pkg::EVT_LINE});
    tally_and_finish();
  end
endmodule // testbench
